// ### hdl/osr_setpoint_regs.sv
// output setpoint command register bank: margin low, slew, loop scale, frequency
// assumes the bus engine delivers whole command words and takes reads byte by byte
//
// What this block does
// - margin-low target is a read/write 16-bit unsigned word at code 26h.
// - margin-low resets to 0123h; any word is taken, 0 V to 127.998 V in 1.953 mV steps.
// - margin-low selected by operation drives the output target from this register.
// - while output is on, target changes from voltage command or margins ramp at programmed slew rate; while off they jump.
// - turning output on or off bypasses the programmed slew rate.
// - slew register: exponent bits 15:11 fixed -4, signed mantissa bits 10:0.
// - slew resets to E002h; accepts 0.0625 to 2 mV/us in 0.0625 steps.
// - illegal writes to slew, scale or frequency are dropped and flagged.
// - loop scale at code 29h uses linear11 with exponent fixed at -3.
// - loop scale accepts only E808h, E804h, E802h, E801h.
// - strap-set output picks scale automatically from voltage band.
// - commanded target and sensed voltage both multiplied by the scale.
// - loop scale resets to E808h, factor 1.0.
// - frequency at code 33h in kHz, linear11 with exponent zero.
// - frequency resets to 0258h; accepts 300 to 1500 kHz in 50 kHz steps.
// - output voltage words use fixed exponent -9, one count is 2^-9 V.
`timescale 1ns/1ps
`default_nettype none
module osr_setpoint_regs
  import osr_pkg::*;
#(
  parameter int WORD_W = 16
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic wr_stb,
  input wire logic [WORD_W-1:0] wr_data,
  input wire logic rd_stb,
  input wire logic cmd_error_clr,
  input wire logic margin_low_sel,
  input wire logic margin_high_sel,
  input wire logic [WORD_W-1:0] margin_high_word,
  input wire logic [WORD_W-1:0] output_voltage_target,
  input wire logic output_on,
  input wire logic strap_mode,
  input wire logic [WORD_W-1:0] resistor_strap_setting_pin,
  input wire logic [WORD_W-1:0] sensed_diff_word,
  output logic [7:0] rd_byte_q,
  output logic rd_byte_valid_q,
  output logic cmd_error_q,
  output logic reject_pulse_q,
  output logic [WORD_W-1:0] target_word_q,
  output logic [WORD_W-1:0] scaled_target_q,
  output logic [WORD_W-1:0] scaled_sense_q,
  output logic [1:0] scale_sel_q,
  output logic [10:0] switch_khz_q,
  output logic [4:0] output_format_exponent_q
);
  import osr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [WORD_W-1:0] margin_low_target;
    logic [WORD_W-1:0] output_slew_rate;
    logic [WORD_W-1:0] loop_scale_factor;
    logic [WORD_W-1:0] switching_rate_khz;
    logic cmd_error;
    logic reject_pulse;
    osr_rd_state_t rd_state;
    logic [7:0] rd_byte;
    logic rd_valid;
    logic [7:0] rd_hi_byte;
    logic on_prev;
    osr_scale_sel_t scale_sel;
    logic [WORD_W-1:0] target_word;
    logic [WORD_W-1:0] scaled_target;
    logic [WORD_W-1:0] scaled_sense;
  } osr_regs_state_t;

  localparam osr_regs_state_t RESET_STATE = '{
    margin_low_target: RST_MARGIN_LOW,
    output_slew_rate: RST_SLEW_RATE,
    loop_scale_factor: RST_LOOP_SCALE,
    switching_rate_khz: RST_SWITCH_KHZ,
    cmd_error: 1'b0,
    reject_pulse: 1'b0,
    rd_state: RD_IDLE,
    rd_byte: 8'h00,
    rd_valid: 1'b0,
    rd_hi_byte: 8'h00,
    on_prev: 1'b0,
    scale_sel: SEL_ONE,
    target_word: '0,
    scaled_target: '0,
    scaled_sense: '0
  };

  osr_regs_state_t s_q, s_d;

  logic wr_known;
  logic wr_legal;
  logic [WORD_W-1:0] setpoint;
  logic ramp_bypass;
  logic [WORD_W-1:0] ramp_target;
  logic [WORD_W-1:0] rd_word;
  osr_scale_sel_t band_sel;

  ////////////////////////////////////////////////////////////////////////////
  // write legality

  osr_write_check u_check (
    .code(cmd_code),
    .data(wr_data),
    .known(wr_known),
    .legal(wr_legal)
  );

  ////////////////////////////////////////////////////////////////////////////
  // setpoint source and slew ramp

  always_comb begin
    if (margin_low_sel) begin
      setpoint = s_q.margin_low_target;
    end else if (margin_high_sel) begin
      setpoint = margin_high_word;
    end else begin
      setpoint = output_voltage_target;
    end
    // off, or first cycle on, jumps without slewing
    ramp_bypass = !output_on || !s_q.on_prev;
  end

  osr_slew_ramp #(
    .WORD_W(WORD_W)
  ) u_ramp (
    .clk(clk),
    .rst(rst),
    .setpoint(setpoint),
    .rate_man(s_q.output_slew_rate[MAN_W-1:0]),
    .bypass(ramp_bypass),
    .target(ramp_target)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strap voltage band to scale, counts of 2^-9 V

  always_comb begin
    if (resistor_strap_setting_pin <= BAND_ONE_MAX) begin
      band_sel = SEL_ONE;
    end else if (resistor_strap_setting_pin <= BAND_HALF_MAX) begin
      band_sel = SEL_HALF;
    end else if (resistor_strap_setting_pin <= BAND_QUARTER_MAX) begin
      band_sel = SEL_QUARTER;
    end else begin
      band_sel = SEL_EIGHTH;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read word select

  always_comb begin
    case (cmd_code)
      CMD_MARGIN_LOW: rd_word = s_q.margin_low_target;
      CMD_SLEW_RATE: rd_word = s_q.output_slew_rate;
      CMD_LOOP_SCALE: rd_word = s_q.loop_scale_factor;
      CMD_SWITCH_KHZ: rd_word = s_q.switching_rate_khz;
      default: rd_word = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.reject_pulse = 1'b0;
    s_d.rd_valid = 1'b0;
    s_d.on_prev = output_on;

    // writes: only legal words land; illegal ones only raise the flag
    if (wr_stb) begin
      if (wr_known && wr_legal) begin
        case (cmd_code)
          CMD_MARGIN_LOW: s_d.margin_low_target = wr_data;
          CMD_SLEW_RATE: s_d.output_slew_rate = wr_data;
          CMD_LOOP_SCALE: s_d.loop_scale_factor = wr_data;
          CMD_SWITCH_KHZ: s_d.switching_rate_khz = wr_data;
          default: s_d.reject_pulse = 1'b0;
        endcase
      end else begin
        s_d.reject_pulse = 1'b1;
      end
    end

    // error flag: a new reject beats a clear in the same cycle
    if (cmd_error_clr) begin
      s_d.cmd_error = 1'b0;
    end
    if (s_d.reject_pulse) begin
      s_d.cmd_error = 1'b1;
    end

    // word reads: low byte, then high byte on the next cycle
    case (s_q.rd_state)
      RD_IDLE: begin
        if (rd_stb) begin
          s_d.rd_byte = rd_word[7:0];
          s_d.rd_hi_byte = rd_word[15:8];
          s_d.rd_valid = 1'b1;
          s_d.rd_state = RD_HIGH;
        end
      end
      RD_HIGH: begin
        s_d.rd_byte = s_q.rd_hi_byte;
        s_d.rd_valid = 1'b1;
        s_d.rd_state = RD_IDLE;
      end
      default: s_d.rd_state = RD_IDLE;
    endcase

    // scale source: strap band or loop scale register
    if (strap_mode) begin
      s_d.scale_sel = band_sel;
    end else begin
      s_d.scale_sel = osr_scale_decode(s_q.loop_scale_factor);
    end

    // loop inputs scaled by 1, 1/2, 1/4 or 1/8
    s_d.target_word = ramp_target;
    s_d.scaled_target = ramp_target >> s_q.scale_sel;
    s_d.scaled_sense = sensed_diff_word >> s_q.scale_sel;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  logic [4:0] fmt_exp_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt_exp_q <= VOUT_EXP;
    end else begin
      fmt_exp_q <= VOUT_EXP;
    end
  end

  assign rd_byte_q = s_q.rd_byte;
  assign rd_byte_valid_q = s_q.rd_valid;
  assign cmd_error_q = s_q.cmd_error;
  assign reject_pulse_q = s_q.reject_pulse;
  assign target_word_q = s_q.target_word;
  assign scaled_target_q = s_q.scaled_target;
  assign scaled_sense_q = s_q.scaled_sense;
  assign scale_sel_q = s_q.scale_sel;
  assign switch_khz_q = s_q.switching_rate_khz[MAN_W-1:0];
  assign output_format_exponent_q = fmt_exp_q;

endmodule
`default_nettype wire

// ### hdl/osr_pkg.sv
// constants and types shared by the setpoint command register bank
// assumes a 100 MHz core clock and word-wide command writes from the bus engine
package osr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_SLEW_RATE = 8'h27;
  localparam logic [7:0] CMD_LOOP_SCALE = 8'h29;
  localparam logic [7:0] CMD_SWITCH_KHZ = 8'h33;

  ////////////////////////////////////////////////////////////////////////////
  // reset values loaded from non-volatile defaults
  localparam logic [15:0] RST_MARGIN_LOW = 16'h0123;
  localparam logic [15:0] RST_SLEW_RATE = 16'hE002;
  localparam logic [15:0] RST_LOOP_SCALE = 16'hE808;
  localparam logic [15:0] RST_SWITCH_KHZ = 16'h0258;

  ////////////////////////////////////////////////////////////////////////////
  // linear11 field layout
  localparam int EXP_LSB = 11;
  localparam int EXP_W = 5;
  localparam int MAN_W = 11;
  localparam logic [4:0] VOUT_EXP = 5'h17;
  localparam logic [4:0] SLEW_EXP = 5'h1C;
  localparam logic [4:0] SCALE_EXP = 5'h1D;
  localparam logic [4:0] KHZ_EXP = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // legal values
  localparam logic [10:0] SLEW_MAN_MIN = 11'h001;
  localparam logic [10:0] SLEW_MAN_MAX = 11'h020;
  localparam logic [10:0] KHZ_MIN = 11'h12C;
  localparam logic [10:0] KHZ_MAX = 11'h5DC;
  localparam logic [10:0] KHZ_STEP = 11'h032;
  localparam logic [15:0] SCALE_ONE = 16'hE808;
  localparam logic [15:0] SCALE_HALF = 16'hE804;
  localparam logic [15:0] SCALE_QUARTER = 16'hE802;
  localparam logic [15:0] SCALE_EIGHTH = 16'hE801;

  ////////////////////////////////////////////////////////////////////////////
  // strap voltage bands in output counts (2^-9 V each)
  localparam logic [15:0] BAND_ONE_MAX = 16'h0399;
  localparam logic [15:0] BAND_HALF_MAX = 16'h0699;
  localparam logic [15:0] BAND_QUARTER_MAX = 16'h0A00;

  ////////////////////////////////////////////////////////////////////////////
  // timing: slew credit counted in 1/125 of an output count per microsecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int MICROSECOND_NS = 1000;
  localparam int CYC_PER_US = MICROSECOND_NS / CLK_PERIOD_NS;
  localparam logic [7:0] CREDIT_PER_COUNT = 8'h7D;
  localparam int CREDIT_PER_MAN_SHIFT = 2;

  typedef enum logic [1:0] {SEL_ONE, SEL_HALF, SEL_QUARTER, SEL_EIGHTH} osr_scale_sel_t;
  typedef enum logic {RD_IDLE, RD_HIGH} osr_rd_state_t;

  // scale register word to shift selection
  function automatic osr_scale_sel_t osr_scale_decode(input logic [15:0] word);
    case (word)
      SCALE_HALF: osr_scale_decode = SEL_HALF;
      SCALE_QUARTER: osr_scale_decode = SEL_QUARTER;
      SCALE_EIGHTH: osr_scale_decode = SEL_EIGHTH;
      default: osr_scale_decode = SEL_ONE;
    endcase
  endfunction

endpackage

// ### hdl/osr_write_check.sv
// legality check of one command word against the register's format
// assumes code and data stand stable for the cycle of the write strobe
`timescale 1ns/1ps
`default_nettype none
module osr_write_check
  import osr_pkg::*;
(
  input wire logic [7:0] code,
  input wire logic [15:0] data,
  output logic known,
  output logic legal
);
  import osr_pkg::*;

  logic [4:0] exp_field;
  logic [10:0] man_field;

  always_comb begin
    exp_field = data[EXP_LSB +: EXP_W];
    man_field = data[MAN_W-1:0];
    known = 1'b1;
    legal = 1'b0;
    case (code)
      CMD_MARGIN_LOW: legal = 1'b1;
      CMD_SLEW_RATE: begin
        // fixed exponent, positive mantissa 1..32 sixteenths of mV/us
        legal = (exp_field == SLEW_EXP) && (man_field >= SLEW_MAN_MIN)
                && (man_field <= SLEW_MAN_MAX);
      end
      CMD_LOOP_SCALE: begin
        legal = (data == SCALE_ONE) || (data == SCALE_HALF)
                || (data == SCALE_QUARTER) || (data == SCALE_EIGHTH);
      end
      CMD_SWITCH_KHZ: begin
        legal = (exp_field == KHZ_EXP) && (man_field >= KHZ_MIN)
                && (man_field <= KHZ_MAX) && ((man_field % KHZ_STEP) == 11'h000);
      end
      default: known = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ### hdl/osr_slew_ramp.sv
// ramps the output target toward the setpoint at a programmed rate
// assumes rate mantissa in sixteenths of mV/us; bypass jumps directly
`timescale 1ns/1ps
`default_nettype none
module osr_slew_ramp
  import osr_pkg::*;
#(
  parameter int WORD_W = 16
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WORD_W-1:0] setpoint,
  input wire logic [10:0] rate_man,
  input wire logic bypass,
  output logic [WORD_W-1:0] target
);
  import osr_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] target;
    logic [7:0] credit;
    logic [6:0] us_cnt;
  } osr_ramp_state_t;

  osr_ramp_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.us_cnt == 7'(CYC_PER_US - 1)) begin
      s_d.us_cnt = 7'h00;
      s_d.credit = s_q.credit + 8'(rate_man << CREDIT_PER_MAN_SHIFT);
    end else begin
      s_d.us_cnt = s_q.us_cnt + 7'h01;
    end
    if (bypass) begin
      s_d.target = setpoint;
      s_d.credit = 8'h00;
    end else if (s_q.target == setpoint) begin
      s_d.credit = 8'h00;
    end else if (s_d.credit >= CREDIT_PER_COUNT) begin
      s_d.credit = s_d.credit - CREDIT_PER_COUNT;
      if (s_q.target < setpoint) begin
        s_d.target = s_q.target + WORD_W'(1);
      end else begin
        s_d.target = s_q.target - WORD_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign target = s_q.target;

endmodule
`default_nettype wire

// ### tb/osr_host_model.sv
// host side of the command port: word writes, byte-pair reads
// assumes strobes sampled on rising edges; drives on falling edges
`timescale 1ns/1ps
`default_nettype none
module osr_host_model
  import osr_pkg::*;
(
  input wire logic clk,
  output logic [7:0] cmd_code,
  output logic wr_stb,
  output logic [15:0] wr_data,
  output logic rd_stb,
  output logic [15:0] output_voltage_target,
  input wire logic [7:0] rd_byte_q,
  input wire logic rd_byte_valid_q
);
  initial begin
    cmd_code = 8'h00;
    wr_stb = 1'b0;
    wr_data = 16'h0000;
    rd_stb = 1'b0;
    output_voltage_target = 16'h0100;
  end
  // released lines show the inverse of the last value
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd_code = c;
    wr_data = d;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    cmd_code = ~c;
    wr_data = ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] w, output logic v);
    @(negedge clk);
    cmd_code = c;
    rd_stb = 1'b1;
    // low byte stands in the cycle after the accepting edge, high byte one later
    @(negedge clk);
    rd_stb = 1'b0;
    cmd_code = ~c;
    w[7:0] = rd_byte_q;
    v = rd_byte_valid_q;
    @(negedge clk);
    w[15:8] = rd_byte_q;
    v = v & rd_byte_valid_q;
  endtask
  // voltage command travels with its matching loop scale
  task automatic vout(input logic [15:0] v);
    output_voltage_target = v;
    wr(CMD_LOOP_SCALE, v <= BAND_ONE_MAX ? SCALE_ONE : v <= BAND_HALF_MAX ? SCALE_HALF :
       v <= BAND_QUARTER_MAX ? SCALE_QUARTER : SCALE_EIGHTH);
  endtask
endmodule
`default_nettype wire

// ### tb/osr_setpoint_regs_asserts.sv
// port checks of the setpoint register bank
// assumes one clock domain; bound into every bank instance
`timescale 1ns/1ps
`default_nettype none
module osr_setpoint_regs_asserts
  import osr_pkg::*;
#(
  parameter int WORD_W = 16
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic wr_stb,
  input wire logic [WORD_W-1:0] wr_data,
  input wire logic rd_stb,
  input wire logic cmd_error_clr,
  input wire logic margin_low_sel,
  input wire logic margin_high_sel,
  input wire logic [WORD_W-1:0] output_voltage_target,
  input wire logic output_on,
  input wire logic rd_byte_valid_q,
  input wire logic cmd_error_q,
  input wire logic reject_pulse_q,
  input wire logic [WORD_W-1:0] target_word_q,
  input wire logic [WORD_W-1:0] scaled_target_q,
  input wire logic [1:0] scale_sel_q,
  input wire logic [10:0] switch_khz_q,
  input wire logic [4:0] output_format_exponent_q
);
  logic khz_ok, slew_ok, scale_ok;
  assign khz_ok = wr_data[15:11] == 5'h00 && wr_data[10:0] >= KHZ_MIN &&
    wr_data[10:0] <= KHZ_MAX && wr_data[10:0] % KHZ_STEP == 11'h000;
  assign slew_ok = wr_data[15:11] == SLEW_EXP && wr_data[10:0] >= SLEW_MAN_MIN &&
    wr_data[10:0] <= SLEW_MAN_MAX;
  assign scale_ok = wr_data == SCALE_ONE || wr_data == SCALE_HALF ||
    wr_data == SCALE_QUARTER || wr_data == SCALE_EIGHTH;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_to(logic [7:0] c);
    wr_stb && cmd_code == c;
  endsequence
  sequence off_hold;
    (!output_on && !margin_low_sel && !margin_high_sel && $stable(output_voltage_target))[*3];
  endsequence
  ////////////////////////////////////////
  khz_accept_a: assert property (wr_to(CMD_SWITCH_KHZ) ##0 khz_ok |=>
    {5'h00, switch_khz_q} == $past(wr_data) && !reject_pulse_q) else $error("khz write lost");
  khz_reject_a: assert property (wr_to(CMD_SWITCH_KHZ) ##0 !khz_ok |=>
    reject_pulse_q && $stable(switch_khz_q)) else $error("bad khz write taken");
  slew_reject_a: assert property (wr_to(CMD_SLEW_RATE) ##0 !slew_ok |=>
    reject_pulse_q && cmd_error_q) else $error("bad slew write taken");
  scale_reject_a: assert property (wr_to(CMD_LOOP_SCALE) ##0 !scale_ok |=>
    reject_pulse_q && cmd_error_q) else $error("bad scale write taken");
  margin_take_a: assert property (wr_to(CMD_MARGIN_LOW) |=> !reject_pulse_q)
    else $error("margin write refused");
  err_sticky_a: assert property (cmd_error_q && !cmd_error_clr |=> cmd_error_q)
    else $error("error flag dropped");
  exp_fixed_a: assert property (output_format_exponent_q == VOUT_EXP)
    else $error("exponent wrong");
  rd_pair_a: assert property (rd_stb && !$past(rd_stb) |=> rd_byte_valid_q [*2])
    else $error("read bytes missing");
  scaled_target_a: assert property ($stable(scale_sel_q) ##1 $stable(scale_sel_q) |->
    scaled_target_q == (target_word_q >> scale_sel_q)) else $error("scaled target wrong");
  off_jump_a: assert property (off_hold |-> target_word_q == output_voltage_target)
    else $error("target not jumped");
endmodule
bind osr_setpoint_regs osr_setpoint_regs_asserts #(.WORD_W(WORD_W)) chk_i (.clk(clk),
  .rst(rst), .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
  .cmd_error_clr(cmd_error_clr), .margin_low_sel(margin_low_sel),
  .margin_high_sel(margin_high_sel), .output_voltage_target(output_voltage_target),
  .output_on(output_on), .rd_byte_valid_q(rd_byte_valid_q), .cmd_error_q(cmd_error_q),
  .reject_pulse_q(reject_pulse_q), .target_word_q(target_word_q),
  .scaled_target_q(scaled_target_q), .scale_sel_q(scale_sel_q),
  .switch_khz_q(switch_khz_q), .output_format_exponent_q(output_format_exponent_q));
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the setpoint register bank
// assumes the host model drives the command port and voltage command
`timescale 1ns/1ps
`default_nettype none
module tb;
  import osr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0, lo_sel = 1'b0, hi_sel = 1'b0, on = 1'b0, strap = 1'b0;
  logic [15:0] hi_word = 16'h0300, pin = 16'h0100, sense = 16'h0800;
  logic [7:0] code, rd_byte;
  logic [15:0] wdata, vcmd, tgt, s_tgt, s_sense;
  logic wr, rd, rd_vld, err, rej;
  logic [1:0] sel;
  logic [10:0] khz;
  logic [4:0] fexp;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  osr_host_model host (.clk(clk), .cmd_code(code), .wr_stb(wr), .wr_data(wdata),
    .rd_stb(rd), .output_voltage_target(vcmd), .rd_byte_q(rd_byte), .rd_byte_valid_q(rd_vld));
  osr_setpoint_regs #(.WORD_W(16)) dut (.clk(clk), .rst(rst), .cmd_code(code), .wr_stb(wr),
    .wr_data(wdata), .rd_stb(rd), .cmd_error_clr(clr), .margin_low_sel(lo_sel),
    .margin_high_sel(hi_sel), .margin_high_word(hi_word), .output_voltage_target(vcmd),
    .output_on(on), .strap_mode(strap), .resistor_strap_setting_pin(pin),
    .sensed_diff_word(sense), .rd_byte_q(rd_byte), .rd_byte_valid_q(rd_vld),
    .cmd_error_q(err), .reject_pulse_q(rej), .target_word_q(tgt), .scaled_target_q(s_tgt),
    .scaled_sense_q(s_sense), .scale_sel_q(sel), .switch_khz_q(khz),
    .output_format_exponent_q(fexp));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] w;
    logic v;
    host.rd(c, w, v);
    chk("read word", w, exp);
    chk("read valid", {15'h0, v}, 16'h0001);
  endtask
  task automatic wr_bad(input logic [7:0] c, input logic [15:0] d, input logic [15:0] keep);
    host.wr(c, d);
    chk("reject", {14'h0, rej, err}, 16'h0003);
    rdc(c, keep);
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    chk("error clear", {15'h0, err}, 16'h0000);
  endtask
  task automatic settle(input logic [15:0] t);
    repeat (4) @(negedge clk);
    chk("target", tgt, t);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rdc(CMD_MARGIN_LOW, 16'h0123);
    rdc(CMD_SLEW_RATE, 16'hE002);
    rdc(CMD_LOOP_SCALE, 16'hE808);
    rdc(CMD_SWITCH_KHZ, 16'h0258);
    chk("exponent", {11'h0, fexp}, 16'h0017);
    rdc(8'h30, 16'h0000);
  endtask
  task automatic t_writes;
    logic [15:0] bs [5] = '{16'hE000, 16'hE021, 16'hE7FF, 16'hF002, 16'h6002};
    logic [15:0] bk [5] = '{16'h012D, 16'h00FA, 16'h060E, 16'h8258, 16'h0000};
    logic [15:0] gk [3] = '{16'h012C, 16'h05DC, 16'h0258};
    logic [15:0] sc [4] = '{16'hE804, 16'hE802, 16'hE801, 16'hE808};
    host.wr(CMD_SLEW_RATE, 16'hE001);
    rdc(CMD_SLEW_RATE, 16'hE001);
    foreach (bs[i]) wr_bad(CMD_SLEW_RATE, bs[i], 16'hE001);
    host.wr(CMD_SLEW_RATE, 16'hE020);
    rdc(CMD_SLEW_RATE, 16'hE020);
    foreach (gk[i]) begin
      host.wr(CMD_SWITCH_KHZ, gk[i]);
      chk("khz", {5'h0, khz}, gk[i]);
    end
    foreach (bk[i]) wr_bad(CMD_SWITCH_KHZ, bk[i], 16'h0258);
    foreach (sc[i]) begin
      host.wr(CMD_LOOP_SCALE, sc[i]);
      @(negedge clk);
      chk("scale sel", {14'h0, sel}, 16'((i + 1) % 4));
    end
    wr_bad(CMD_LOOP_SCALE, 16'hE803, 16'hE808);
    wr_bad(8'h30, 16'h1234, 16'h0000);
    rdc(CMD_MARGIN_LOW, 16'h0123);
  endtask
  task automatic t_target;
    host.wr(CMD_MARGIN_LOW, 16'h0400);
    rdc(CMD_MARGIN_LOW, 16'h0400);
    lo_sel = 1'b1;
    hi_sel = 1'b1;
    settle(16'h0400);
    lo_sel = 1'b0;
    settle(16'h0300);
    hi_sel = 1'b0;
    host.vout(16'h0800);
    settle(16'h0800);
    chk("scaled target", s_tgt, 16'h0200);
    chk("scaled sense", s_sense, 16'h0200);
    host.vout(16'h0300);
    on = 1'b1;
    settle(16'h0300);
    host.vout(16'h0302);
    repeat (50) @(negedge clk);
    chk("ramp slow", {15'h0, tgt == 16'h0302}, 16'h0000);
    repeat (400) @(negedge clk);
    chk("ramp end", tgt, 16'h0302);
    on = 1'b0;
    host.vout(16'h0100);
    settle(16'h0100);
  endtask
  task automatic t_strap;
    logic [15:0] p [6] = '{16'h0399, 16'h039A, 16'h0699, 16'h069A, 16'h0A00, 16'h0A01};
    logic [1:0] s [6] = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd2, 2'd3};
    strap = 1'b1;
    foreach (p[i]) begin
      pin = p[i];
      repeat (3) @(negedge clk);
      chk("strap scale", {14'h0, sel}, {14'h0, s[i]});
      chk("strap sense", s_sense, 16'h0800 >> s[i]);
    end
    strap = 1'b0;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_writes();
    t_target();
    t_strap();
    close_out();
  end
endmodule
`default_nettype wire
